//--- mem_pad_pkg.sv
// constants for the memory pad-state controller
// What this block does
// [R01] suspend with cas-before-ras refresh: strobes keep being driven from the refresh logic
// [R02] suspend with self-refresh: every enabled strobe is driven low
// [R03] suspend with dram powered down: strobes and write enable float with pulldowns
// [R04] shared upper strobes get suspend treatment only when enabled as strobes
// [R05] dram kept powered in suspend: write enable driven high
// [R06] low data pins pulled down while input, pulldown off while driving
// [R07] top address line floats with pulldown in suspend, any dram mode
// [R08] during reset the five low address pins are inputs with pulldowns
// [R09] all straps low means non-test, 8-bit boot rom on first select, buffers off
// [R10] strap pulldowns switch off once reset has ended
// [R11] in suspend, straps sampled low get their pulldown back
// [R12] in suspend, straps sampled high float without pulldown; the code keeps the test strap (bit 4) pulled down in suspend
// [R13] board fits pullups on straps needing a non-default value
// [R14] address bits four to eleven float with pulldowns in suspend
// [R15] rom controls in suspend: driven high, floating, or floating with pulldown
// [R16] straps latched at reset release and held until the next reset
package mem_pad_pkg;
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  CTRL_OFFSET    = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET  = 4'h4;

  // control register fields
  localparam int          CTRL_W         = 7;
  localparam int          CTRL_DRAM_LSB  = 0;
  localparam int          CTRL_ROM_LSB   = 2;
  localparam int          CTRL_HIGH_RAS  = 4;
  localparam int          CTRL_HIGH_CAS  = 5;
  localparam int          CTRL_TOP_ADDR  = 6;
  localparam logic [6:0]  CTRL_RESET     = 7'h00;

  // status register fields
  localparam int          STAT_STRAP_LSB = 0;
  localparam int          STAT_SUSPEND   = 8;
  localparam int          STAT_VALID     = 9;

  // dram suspend handling
  localparam logic [1:0]  DRAM_CBR       = 2'h0;
  localparam logic [1:0]  DRAM_SELF      = 2'h1;
  localparam logic [1:0]  DRAM_OFF       = 2'h2;

  // rom control suspend handling
  localparam logic [1:0]  ROM_DRIVE_HIGH = 2'h0;
  localparam logic [1:0]  ROM_FLOAT      = 2'h1;
  localparam logic [1:0]  ROM_FLOAT_PD   = 2'h2;

  // straps on the low address pins
  localparam int          STRAP_N        = 5;
  localparam int          STRAP_CFG_N    = 4;
  localparam int          STRAP_ROM_LSB  = 0; // R09
  localparam int          STRAP_BOOT_CS  = 2;
  localparam int          STRAP_BUF_EN   = 3;
  localparam int          STRAP_TEST     = 4;
  localparam logic [4:0]  STRAP_RESET    = 5'h00;

  // pad counts and reset values
  localparam int          STROBE_N       = 12;
  localparam int          LOW_ADDR_N     = 12;
  localparam int          DATA_N         = 16;
  localparam int          ROM_N          = 4;
  localparam logic [11:0] STROBE_OUT_RST = 12'h0fff;
  localparam logic [11:0] STROBE_OE_RST  = 12'h0333;
  localparam logic [11:0] ADDR_OE_RST    = 12'h0fe0;
  localparam logic [11:0] ADDR_PD_RST    = 12'h001f;
  localparam logic [3:0]  ROM_OUT_RST    = 4'hf;
endpackage

//--- strap_capture.sv
// strap pin synchroniser and reset-release latch
module strap_capture #(
  parameter int N = mem_pad_pkg::STRAP_N
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [N-1:0] strap_pin_in,
  output logic      [N-1:0] straps,
  output logic              straps_valid
);
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;

  // no reset here so the pins are sampled while reset is held
  always_ff @(posedge clk)
  begin
    sync1 <= strap_pin_in;
    sync2 <= sync1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      straps       <= mem_pad_pkg::STRAP_RESET;
      straps_valid <= 1'b0;
    end
    else if (!straps_valid)
    begin
      straps       <= sync2; // R16
      straps_valid <= 1'b1;
    end
  end

  property p_strap_hold;
    @(posedge clk) disable iff (reset)
    $past(straps_valid) |-> straps_valid && $stable(straps);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps changed after capture"); // R16

  property p_strap_once;
    @(posedge clk) disable iff (reset)
    !straps_valid ##1 !straps_valid |=> straps_valid && straps == $past(sync2);
  endproperty
  a_strap_once: assert property (p_strap_once) else $error("straps not taken in first cycle"); // R16
endmodule

//--- mem_pad_ctrl.sv
// memory interface pad-state controller with avalon register slave
module mem_pad_ctrl (
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // power manager, same clock
  input  wire logic        suspend,
  // memory controller side, same clock
  input  wire logic [11:0] strobe_n_in,
  input  wire logic        write_enable_n_in,
  input  wire logic [12:0] mem_addr_in,
  input  wire logic [15:0] data_wr_in,
  input  wire logic        data_drive_in,
  input  wire logic [3:0]  rom_ctl_n_in,
  output logic      [15:0] data_rd,
  // pads
  output logic      [11:0] strobe_n_out,
  output logic      [11:0] strobe_oe,
  output logic      [11:0] strobe_pd,
  output logic             dram_write_enable_n,
  output logic             dram_write_enable_oe,
  output logic             dram_write_enable_pd,
  output logic      [11:0] mem_addr_out,
  output logic      [11:0] mem_addr_oe,
  output logic      [11:0] mem_addr_pd,
  input  wire logic [4:0]  strap_pin_in,
  output logic             top_mem_addr_line,
  output logic             top_mem_addr_line_oe,
  output logic             top_mem_addr_line_pd,
  output logic      [15:0] data_out,
  output logic             data_oe,
  output logic             data_pd,
  input  wire logic [15:0] data_pin_in,
  output logic      [3:0]  rom_ctl_n_out,
  output logic             rom_ctl_oe,
  output logic             rom_ctl_pd,
  // latched straps
  output logic      [4:0]  straps,
  output logic             straps_valid
);
  logic [6:0]  ctrl;
  logic [15:0] data_sync1;
  logic [15:0] data_sync2;

  strap_capture #(
    .N (mem_pad_pkg::STRAP_N)
  ) u_straps (
    .clk          (clk),
    .reset        (reset),
    .strap_pin_in (strap_pin_in),
    .straps       (straps),
    .straps_valid (straps_valid)
  );

  // register decode
  wire        sel_ctrl    = avs_address == mem_pad_pkg::CTRL_OFFSET;
  wire        sel_status  = avs_address == mem_pad_pkg::STATUS_OFFSET;
  wire        wr_take     = avs_write && !avs_waitrequest;
  wire        req_new     = (avs_read || avs_write) && avs_waitrequest;
  wire [31:0] status_word = {22'h00_0000, straps_valid, suspend, 3'h0, straps};
  wire [31:0] next_readdata = sel_ctrl ? {25'h000_0000, ctrl} : (sel_status ? status_word : 32'h0000_0000);

  wire [1:0]  dram_mode   = ctrl[mem_pad_pkg::CTRL_DRAM_LSB +: 2];
  wire [1:0]  rom_mode    = ctrl[mem_pad_pkg::CTRL_ROM_LSB +: 2];
  wire        high_ras    = ctrl[mem_pad_pkg::CTRL_HIGH_RAS];
  wire        high_cas    = ctrl[mem_pad_pkg::CTRL_HIGH_CAS];
  wire        dram_self   = dram_mode == mem_pad_pkg::DRAM_SELF;
  // unused code 3 is treated as powered down, the safe choice for the dram
  wire        dram_off    = dram_mode == mem_pad_pkg::DRAM_OFF || dram_mode == 2'h3;
  wire        susp_off    = suspend && dram_off;
  wire        susp_self   = suspend && dram_self;

  // strobe layout: [3:0] row, [7:4] column high, [11:8] column low; bits 3:2 of each shared
  wire [11:0] strobe_en   = {high_cas, high_cas, 2'b11, high_cas, high_cas, 2'b11, high_ras, high_ras, 2'b11};

  logic [11:0] next_strobe_out;
  logic [11:0] next_strobe_oe;
  logic [11:0] next_strobe_pd;
  logic [11:0] next_addr_oe;
  logic [11:0] next_addr_pd;

  genvar i;
  generate
    for (i = 0; i < mem_pad_pkg::STROBE_N; i++)
    begin : g_strobe
      // a shared pin not enabled as a strobe is left to its other function
      assign next_strobe_oe[i]  = strobe_en[i] && !susp_off; // R03 R04
      assign next_strobe_pd[i]  = strobe_en[i] && susp_off; // R03 R04
      assign next_strobe_out[i] = susp_self ? 1'b0 : strobe_n_in[i]; // R01 R02
    end
    for (i = 0; i < mem_pad_pkg::LOW_ADDR_N; i++)
    begin : g_addr
      if (i < mem_pad_pkg::STRAP_CFG_N)
      begin : g_cfg
        assign next_addr_oe[i] = !suspend && straps_valid; // R10
        assign next_addr_pd[i] = suspend ? !straps[i] : !straps_valid; // R11 R12 R10
      end
      else if (i < mem_pad_pkg::STRAP_N)
      begin : g_test
        assign next_addr_oe[i] = !suspend && straps_valid; // R10
        assign next_addr_pd[i] = suspend || !straps_valid; // R14
      end
      else
      begin : g_plain
        assign next_addr_oe[i] = !suspend; // R14
        assign next_addr_pd[i] = suspend; // R14
      end
    end
  endgenerate

  wire        next_we_oe   = !susp_off; // R03
  wire        next_we_pd   = susp_off; // R03
  wire        next_we_n    = suspend ? 1'b1 : write_enable_n_in; // R05
  wire        next_top_oe  = !suspend && ctrl[mem_pad_pkg::CTRL_TOP_ADDR];
  wire        next_top_pd  = suspend; // R07
  wire        next_data_oe = data_drive_in && !suspend;
  wire        next_data_pd = !next_data_oe; // R06
  wire        rom_float    = suspend && rom_mode != mem_pad_pkg::ROM_DRIVE_HIGH; // R15
  wire        next_rom_pd  = rom_float && rom_mode != mem_pad_pkg::ROM_FLOAT; // R15
  wire [3:0]  next_rom_out = suspend ? 4'hf : rom_ctl_n_in; // R15

  // register slave: one wait-free cycle per request
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      ctrl            <= mem_pad_pkg::CTRL_RESET;
    end
    else
    begin
      avs_waitrequest <= !req_new;
      if (avs_read && avs_waitrequest)
        avs_readdata <= next_readdata;
      if (wr_take && sel_ctrl)
        ctrl <= avs_writedata[6:0];
    end
  end

  always_ff @(posedge clk)
  begin
    data_sync1 <= data_pin_in;
    data_sync2 <= data_sync1;
  end

  // pad state; reset values hold the pin states seen while reset is applied
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      strobe_n_out         <= mem_pad_pkg::STROBE_OUT_RST;
      strobe_oe            <= mem_pad_pkg::STROBE_OE_RST;
      strobe_pd            <= 12'h000;
      dram_write_enable_n  <= 1'b1;
      dram_write_enable_oe <= 1'b1;
      dram_write_enable_pd <= 1'b0;
      mem_addr_out         <= 12'h000;
      mem_addr_oe          <= mem_pad_pkg::ADDR_OE_RST; // R08
      mem_addr_pd          <= mem_pad_pkg::ADDR_PD_RST; // R08
      top_mem_addr_line    <= 1'b0;
      top_mem_addr_line_oe <= 1'b0;
      top_mem_addr_line_pd <= 1'b0;
      data_out             <= 16'h0000;
      data_oe              <= 1'b0;
      data_pd              <= 1'b1;
      data_rd              <= 16'h0000;
      rom_ctl_n_out        <= mem_pad_pkg::ROM_OUT_RST;
      rom_ctl_oe           <= 1'b1;
      rom_ctl_pd           <= 1'b0;
    end
    else
    begin
      strobe_n_out         <= next_strobe_out;
      strobe_oe            <= next_strobe_oe;
      strobe_pd            <= next_strobe_pd;
      dram_write_enable_n  <= next_we_n;
      dram_write_enable_oe <= next_we_oe;
      dram_write_enable_pd <= next_we_pd;
      mem_addr_out         <= mem_addr_in[11:0];
      mem_addr_oe          <= next_addr_oe;
      mem_addr_pd          <= next_addr_pd;
      top_mem_addr_line    <= mem_addr_in[12];
      top_mem_addr_line_oe <= next_top_oe;
      top_mem_addr_line_pd <= next_top_pd;
      data_out             <= data_wr_in;
      data_oe              <= next_data_oe;
      data_pd              <= next_data_pd;
      data_rd              <= data_sync2;
      rom_ctl_n_out        <= next_rom_out;
      rom_ctl_oe           <= !rom_float;
      rom_ctl_pd           <= next_rom_pd;
    end
  end

  // checks start one edge after release, when the pad registers have left their reset values
  logic        out_of_reset;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      out_of_reset <= 1'b0;
    else
      out_of_reset <= 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !out_of_reset);

  property p_cbr_active;
    (suspend && dram_mode == mem_pad_pkg::DRAM_CBR) |=> strobe_oe[1:0] == 2'b11 && strobe_n_out == $past(strobe_n_in);
  endproperty
  a_cbr_active: assert property (p_cbr_active) else $error("strobes not live in cbr suspend"); // R01

  property p_self_low;
    susp_self |=> (strobe_n_out & strobe_oe) == 12'h000 && strobe_oe[0];
  endproperty
  a_self_low: assert property (p_self_low) else $error("strobes not low in self refresh"); // R02

  property p_off_float;
    susp_off |=> !dram_write_enable_oe && dram_write_enable_pd && strobe_oe == 12'h000 && strobe_pd[0];
  endproperty
  a_off_float: assert property (p_off_float) else $error("dram pins not floated with pulldown"); // R03

  property p_shared_untouched;
    (!high_ras && !high_cas) |=> (strobe_oe & 12'h0ccc) == 12'h000 && (strobe_pd & 12'h0ccc) == 12'h000;
  endproperty
  a_shared_untouched: assert property (p_shared_untouched) else $error("disabled shared strobe altered"); // R04

  property p_we_high;
    (suspend && !dram_off) |=> dram_write_enable_n && dram_write_enable_oe;
  endproperty
  a_we_high: assert property (p_we_high) else $error("write enable not driven high"); // R05

  property p_data_pd;
    ##1 data_pd == !data_oe && data_oe == ($past(data_drive_in) && !$past(suspend));
  endproperty
  a_data_pd: assert property (p_data_pd) else $error("data pulldown wrong for direction"); // R06

  property p_top_addr;
    suspend |=> !top_mem_addr_line_oe && top_mem_addr_line_pd;
  endproperty
  a_top_addr: assert property (p_top_addr) else $error("top address not floated in suspend"); // R07

  property p_straps_off;
    (!suspend && straps_valid) |=> mem_addr_pd == 12'h000 && mem_addr_oe == 12'hfff;
  endproperty
  a_straps_off: assert property (p_straps_off) else $error("pads wrong in normal operation"); // R10 R14

  property p_strap_suspend;
    (suspend && straps_valid) |=> mem_addr_pd[3:0] == ~straps[3:0] && mem_addr_pd[11:4] == 8'hff && mem_addr_oe == 12'h000;
  endproperty
  a_strap_suspend: assert property (p_strap_suspend) else $error("strap pads wrong in suspend"); // R11 R12 R14

  property p_rom_modes;
    suspend |=> (rom_ctl_oe == ($past(rom_mode) == mem_pad_pkg::ROM_DRIVE_HIGH))
                && rom_ctl_pd == ($past(rom_mode) >= mem_pad_pkg::ROM_FLOAT_PD) && rom_ctl_n_out == 4'hf;
  endproperty
  a_rom_modes: assert property (p_rom_modes) else $error("rom control suspend state wrong"); // R15

  property p_rom_normal;
    !suspend |=> rom_ctl_oe && !rom_ctl_pd && rom_ctl_n_out == $past(rom_ctl_n_in);
  endproperty
  a_rom_normal: assert property (p_rom_normal) else $error("rom controls not driven in normal operation"); // R15

  property p_we_normal;
    !suspend |=> dram_write_enable_oe && !dram_write_enable_pd && dram_write_enable_n == $past(write_enable_n_in);
  endproperty
  a_we_normal: assert property (p_we_normal) else $error("write enable not driven in normal operation"); // R03

  property p_reset_straps;
    disable iff (1'b0) reset ##1 reset |-> mem_addr_oe[4:0] == 5'h00 && mem_addr_pd[4:0] == 5'h1f;
  endproperty
  a_reset_straps: assert property (p_reset_straps) else $error("strap pins not pulled down in reset"); // R08

  property p_strap_pending;
    (!straps_valid && !suspend) |=> mem_addr_oe[4:0] == 5'h00 && mem_addr_pd[4:0] == 5'h1f;
  endproperty
  a_strap_pending: assert property (p_strap_pending) else $error("strap pins driven before capture"); // R08 R10

  property p_wait_one;
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("request not answered after one cycle");

  property p_wait_back;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_back: assert property (p_wait_back) else $error("waitrequest low for more than one cycle");

  property p_ctrl_write;
    (avs_write && !avs_waitrequest && sel_ctrl) |=> {25'h000_0000, ctrl} == ($past(avs_writedata) & 32'h0000_007f);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

  property p_ctrl_read;
    (avs_read && avs_waitrequest && sel_ctrl) |=> avs_readdata == {25'h000_0000, ctrl};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read data wrong");
endmodule

//--- mem_far_side.sv
// far-side model: board strap resistors and external memory data pins
module mem_far_side (
  input  wire logic        clk,
  input  wire logic [4:0]  strap_pullup,
  input  wire logic [11:0] mem_addr_out,
  input  wire logic [11:0] mem_addr_oe,
  input  wire logic [11:0] mem_addr_pd,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic        data_pd,
  input  wire logic [15:0] mem_data,
  input  wire logic        mem_drive,
  output logic      [4:0]  strap_pin_in,
  output logic      [15:0] data_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic toggle = 1'b0;
  // an undriven unpulled pin wanders instead of holding its last level
  always @(posedge clk)
    toggle <= ~toggle;
  always_comb
  begin
    for (int i = 0; i < 5; i++)
      if (mem_addr_oe[i])
        strap_pin_in[i] = mem_addr_out[i];
      else if (strap_pullup[i])
        strap_pin_in[i] = 1'b1;
      else if (mem_addr_pd[i])
        strap_pin_in[i] = 1'b0;
      else
        strap_pin_in[i] = toggle;
    if (data_oe)
      data_pin_in = data_out;
    else if (mem_drive)
      data_pin_in = mem_data;
    else if (data_pd)
      data_pin_in = 16'h0000;
    else
      data_pin_in = {16{toggle}};
  end
endmodule

//--- tb_top.sv
// self-checking testbench for the memory pad-state controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest, suspend, write_enable_n_in, data_drive_in;
  logic [3:0]  avs_address, rom_ctl_n_in, rom_ctl_n_out;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [11:0] strobe_n_in, strobe_n_out, strobe_oe, strobe_pd, mem_addr_out, mem_addr_oe, mem_addr_pd;
  logic [12:0] mem_addr_in;
  logic [15:0] data_wr_in, data_rd, data_out, data_pin_in, mem_data;
  logic        dram_write_enable_n, dram_write_enable_oe, dram_write_enable_pd, data_oe, data_pd;
  logic        top_mem_addr_line, top_mem_addr_line_oe, top_mem_addr_line_pd, rom_ctl_oe, rom_ctl_pd;
  logic        straps_valid, mem_drive, dd;
  logic [4:0]  strap_pin_in, straps, strap_pu;
  logic [6:0]  ctrl;
  int          failures, cmp_count, cycles;

  mem_pad_ctrl dut_u (
    .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .suspend, .strobe_n_in, .write_enable_n_in, .mem_addr_in, .data_wr_in, .data_drive_in, .rom_ctl_n_in,
    .data_rd, .strobe_n_out, .strobe_oe, .strobe_pd, .dram_write_enable_n, .dram_write_enable_oe,
    .dram_write_enable_pd, .mem_addr_out, .mem_addr_oe, .mem_addr_pd, .strap_pin_in, .top_mem_addr_line,
    .top_mem_addr_line_oe, .top_mem_addr_line_pd, .data_out, .data_oe, .data_pd, .data_pin_in,
    .rom_ctl_n_out, .rom_ctl_oe, .rom_ctl_pd, .straps, .straps_valid
  );
  mem_far_side far_u (
    .clk, .strap_pullup(strap_pu), .mem_addr_out, .mem_addr_oe, .mem_addr_pd, .data_out, .data_oe,
    .data_pd, .mem_data, .mem_drive, .strap_pin_in, .data_pin_in
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results();
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
      check(avs_waitrequest, 0, "no bus answer");
  endtask

  function automatic logic [11:0] strobe_mask(input logic [6:0] c);
    return 12'h0333 | (c[4] ? 12'h000c : 12'h0000) | (c[5] ? 12'h0cc0 : 12'h0000);
  endfunction

  task automatic check_pads();
    logic [11:0] en;
    logic [11:0] m;
    logic        off;
    en = strobe_mask(ctrl);
    off = ctrl[1];
    m = off ? 12'h000 : en;
    if (!suspend)
    begin
      check({strobe_oe, strobe_pd}, {en, 12'h000}, "strobes");
      check(strobe_n_out & en, strobe_n_in & en, "strobe values");
      check({dram_write_enable_n, dram_write_enable_oe, dram_write_enable_pd}, {write_enable_n_in, 2'b10}, "we");
      check({mem_addr_oe, mem_addr_pd}, {12'h0fff, 12'h0000}, "addr pads");
      check(mem_addr_out, mem_addr_in[11:0], "addr out");
      check({top_mem_addr_line_oe, top_mem_addr_line & ctrl[6]}, {ctrl[6], mem_addr_in[12] & ctrl[6]}, "top");
      check({data_oe, data_pd}, {dd, ~dd}, "data pads");
      check(data_out & {16{dd}}, data_wr_in & {16{dd}}, "data out");
      check({rom_ctl_n_out, rom_ctl_oe, rom_ctl_pd}, {rom_ctl_n_in, 2'b10}, "rom");
      check(data_rd, dd ? data_wr_in : mem_data, "data read path");
    end
    else
    begin
      check({strobe_oe, strobe_pd}, {m, off ? en : 12'h000}, "suspend strobe pads");
      check(strobe_n_out & m, ctrl[1:0] == mem_pad_pkg::DRAM_SELF ? 12'h000 : strobe_n_in & m, "refresh");
      check({dram_write_enable_oe, dram_write_enable_pd, dram_write_enable_n | off}, {~off, off, 1'b1}, "we");
      check({mem_addr_oe, mem_addr_pd}, {12'h000, 8'hff, ~strap_pu[3:0]}, "suspend addr");
      check({top_mem_addr_line_oe, top_mem_addr_line_pd}, 2'b01, "suspend top");
      check({data_oe, data_pd}, 2'b01, "suspend data");
      check({rom_ctl_oe, rom_ctl_pd, rom_ctl_n_out | {4{ctrl[3:2] != 2'h0}}}, {ctrl[3:2] == 2'h0, ctrl[3], 4'hf},
            "suspend rom");
      check(straps, strap_pu, "straps held");
    end
  endtask

  initial
  begin
    void'($urandom(32'h4a74));
    {reset, avs_read, avs_write, avs_address, avs_writedata, suspend} = {3'b100, 36'h0_0000_0000, 1'b0};
    {strobe_n_in, write_enable_n_in, mem_addr_in, data_wr_in, data_drive_in, rom_ctl_n_in} = '0;
    {mem_data, mem_drive, dd, ctrl, failures, cmp_count, cycles} = '0;
    strap_pu = 5'($urandom) & 5'h0f;
    repeat (3) @(posedge clk);
    #1;
    check({mem_addr_oe, mem_addr_pd}, {12'h0fe0, 12'h001f}, "reset addr pads");
    repeat (7) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({straps_valid, straps}, {1'b1, strap_pu}, "latched straps");
    bus(1'b1, mem_pad_pkg::STATUS_OFFSET, 32'hffff_ffff, rd);
    bus(1'b1, 4'h8, 32'hffff_ffff, rd);
    bus(1'b0, mem_pad_pkg::CTRL_OFFSET, 32'h0000_0000, rd);
    check(rd, 0, "ctrl after ignored writes");
    bus(1'b0, 4'hc, 32'h0000_0000, rd);
    check(rd, 0, "unmapped read");
    for (int i = 0; i < 32; i++)
    begin
      ctrl = {3'($urandom), i[3:0]};
      bus(1'b1, mem_pad_pkg::CTRL_OFFSET, {25'h0, ctrl}, rd);
      bus(1'b0, mem_pad_pkg::CTRL_OFFSET, 32'h0000_0000, rd);
      check(rd, {25'h0, ctrl}, "ctrl readback");
      dd = 1'($urandom);
      strobe_n_in <= 12'($urandom);
      write_enable_n_in <= 1'($urandom);
      mem_addr_in <= 13'($urandom);
      data_wr_in <= 16'($urandom);
      rom_ctl_n_in <= 4'($urandom);
      mem_data <= 16'($urandom);
      data_drive_in <= dd;
      mem_drive <= ~dd;
      repeat (5) @(posedge clk);
      #1;
      check_pads();
      @(posedge clk);
      suspend <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check_pads();
      bus(1'b0, mem_pad_pkg::STATUS_OFFSET, 32'h0000_0000, rd);
      check(rd, {22'h0, 2'b11, 3'h0, strap_pu}, "status");
      suspend <= 1'b0;
    end
    // second reset with every strap left at its pulled-down default
    @(posedge clk);
    reset <= 1'b1;
    strap_pu <= 5'h00;
    ctrl = 7'h00;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({straps_valid, straps}, {1'b1, 5'h00}, "default straps");
    @(posedge clk);
    suspend <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_pads();
    results();
  end
endmodule
